// *** verilog/rtcoc_pkg.sv ***
//==============================================================================
// Purpose : Constants and types for the real-time clock oscillator control block
// Assumes : 32-bit AXI4-Lite register access, one word per register
// Notes   : Register byte address is four times the register index
//==============================================================================
// Summary of operation
// - Oscillator control resets zero; bits 2:0 read zero
// - Control bit 7 enables automatic gain control
// - Control bit 6: 0 self-oscillate, 1 crystal
// - Control bit 5 enables doubled oscillator bias
// - Amplitude ok reads 0 without doubled bias
// - Control bit 3 selects internal oscillator, overrides mode
// - Configuration bit 7 enables capacitance stepping, resets 0
// - Settled reads 1 when capacitance reached target or stepping is disabled
// - Configuration bits 3:0 hold capacitance target
// - Configuration bits 5:4 read zero, ignore writes
// - Match-2 flag set by alarm 2, sticky
// - Alarm event when timer equals alarm value
// - Clear timer one cycle after alarm 0
// - Disabling alarm events clears the event flags
package rtcoc_pkg;

   // ===========================================================================
   // Register indices and widths
   localparam int         ADDR_W        = 8;
   localparam int         DATA_W        = 32;
   localparam logic [5:0] IDX_OSC_CTRL  = 6'h05;
   localparam logic [5:0] IDX_OSC_CFG   = 6'h06;
   localparam logic [5:0] IDX_CLK_CFG   = 6'h07;
   localparam logic [5:0] IDX_ALM_CTRL  = 6'h08;
   localparam logic [5:0] IDX_ALARM0    = 6'h09;
   localparam logic [5:0] IDX_ALARM1    = 6'h0A;
   localparam logic [5:0] IDX_ALARM2    = 6'h0B;
   localparam logic [5:0] IDX_IRQ_STAT  = 6'h0C;
   localparam logic [5:0] IDX_IRQ_MASK  = 6'h0D;

   // ===========================================================================
   // Field positions
   localparam int OC_GAIN_BIT    = 7;
   localparam int OC_MODE_BIT    = 6;
   localparam int OC_BIAS_BIT    = 5;
   localparam int OC_AMP_BIT     = 4;
   localparam int OC_LFO_BIT     = 3;
   localparam int CF_AUTO_BIT    = 7;
   localparam int CF_SETTLED_BIT = 6;
   localparam int CC_FLAG_LSB    = 4;
   localparam int CC_CLR_BIT     = 3;
   localparam int AC_EVENTS_BIT  = 0;
   localparam int IS_SETTLED_BIT = 3;

   // ===========================================================================
   // Reset values and encodings
   localparam logic [3:0] OSC_CTRL_RST  = 4'h0;
   localparam logic [3:0] LOAD_CAP_RST  = 4'h0;
   localparam logic [3:0] CLK_CFG_RST   = 4'h0;
   localparam logic [3:0] IRQ_MASK_RST  = 4'h0;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;
   localparam logic [1:0] SRC_SELF      = 2'h0;
   localparam logic [1:0] SRC_XTAL      = 2'h1;
   localparam logic [1:0] SRC_LFO       = 2'h2;

   // ===========================================================================
   // Timing
   localparam int CLK_PERIOD_NS   = 10;
   localparam int CLEAR_DELAY_CYC = 1;

   // ===========================================================================
   // Carriers
   typedef struct packed {
      logic gain_ctrl_en;
      logic osc_source_mode;
      logic bias_double_en;
      logic internal_lfo_select;
   } rtcoc_osc_ctrl_t;

   typedef struct packed {
      logic [1:0]  resp;
      logic [31:0] data;
   } rtcoc_rd_t;

endpackage

// *** verilog/rtcoc_top.sv ***
//==============================================================================
// Purpose : Oscillator control, load capacitance stepping and alarm flags
// Assumes : Single clock, synchronous inputs, AXI4-Lite slave
// Notes   : Timer value comes from outside; clear request goes back out
//==============================================================================
`timescale 1ns/1ps
`default_nettype none

module rtcoc_top
   import rtcoc_pkg::*;
(
   // Clock, reset, enable
   input  wire logic              clk_sys_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   // AXI4-Lite write address and data
   input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input  wire logic              s_axi_awvalid_i,
   output var  logic              s_axi_awready_o,
   input  wire logic [DATA_W-1:0] s_axi_wdata_i,
   input  wire logic [3:0]        s_axi_wstrb_i,
   input  wire logic              s_axi_wvalid_i,
   output var  logic              s_axi_wready_o,
   // AXI4-Lite write response
   output var  logic [1:0]        s_axi_bresp_o,
   output var  logic              s_axi_bvalid_o,
   input  wire logic              s_axi_bready_i,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input  wire logic              s_axi_arvalid_i,
   output var  logic              s_axi_arready_o,
   output var  logic [DATA_W-1:0] s_axi_rdata_o,
   output var  logic [1:0]        s_axi_rresp_o,
   output var  logic              s_axi_rvalid_o,
   input  wire logic              s_axi_rready_i,
   // Oscillator
   input  wire logic              amplitude_detect_i,
   output var  logic              gain_ctrl_en_o,
   output var  logic              bias_double_en_o,
   output var  logic              lfo_enable_o,
   output var  logic [1:0]        clk_src_o,
   output var  logic [3:0]        load_cap_applied_o,
   // Timer
   input  wire logic [31:0]       timer_value_i,
   output var  logic              timer_clear_o,
   // Interrupt
   output var  logic              irq_o
);

   // ===========================================================================
   // Functions
   function automatic logic [5:0] idx_of(input logic [ADDR_W-1:0] a);
      idx_of = a[7:2];
   endfunction

   function automatic logic mapped(input logic [5:0] i);
      mapped = (i >= IDX_OSC_CTRL) && (i <= IDX_IRQ_MASK);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      merge = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
         begin
            merge[8*b +: 8] = new_v[8*b +: 8];
         end
      end
   endfunction

   // ===========================================================================
   // State
   logic            awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [1:0]      bresp_r;
   rtcoc_rd_t       rd_r;
   logic [5:0]      wr_idx_r;
   logic [31:0]     wdata_r;
   logic [3:0]      wstrb_r;
   rtcoc_osc_ctrl_t ctrl_r;
   logic            amp_ok_r;
   logic            auto_step_r;
   logic [3:0]      target_r, applied_r;
   logic [3:0]      clk_cfg_r;
   logic [2:0]      flag_r;
   logic            events_en_r;
   logic [31:0]     alarm_r [3];
   logic [2:0]      match_d_r;
   logic            settled_d_r;
   logic [3:0]      stat_r, mask_r;
   logic [1:0]      clk_src_r;
   logic            clr_r, irq_r;

   // ===========================================================================
   // Bus decode
   wire logic        aw_take  = s_axi_awvalid_i & awready_r;
   wire logic        w_take   = s_axi_wvalid_i & wready_r;
   wire logic        wr_fire  = ~awready_r & ~wready_r & ~bvalid_r;
   wire logic        b_take   = bvalid_r & s_axi_bready_i;
   wire logic        ar_take  = s_axi_arvalid_i & arready_r;
   wire logic        r_take   = rvalid_r & s_axi_rready_i;
   wire logic [5:0]  ar_idx   = idx_of(s_axi_araddr_i);
   wire logic        wr_ok    = wr_fire & mapped(wr_idx_r);
   wire logic        wr_lane0 = wr_fire & wstrb_r[0];
   wire logic        wr_ctrl  = wr_lane0 & (wr_idx_r == IDX_OSC_CTRL);
   wire logic        wr_cfg   = wr_lane0 & (wr_idx_r == IDX_OSC_CFG);
   wire logic        wr_clk   = wr_lane0 & (wr_idx_r == IDX_CLK_CFG);
   wire logic        wr_alm   = wr_lane0 & (wr_idx_r == IDX_ALM_CTRL);
   wire logic        wr_mask  = wr_lane0 & (wr_idx_r == IDX_IRQ_MASK);
   wire logic        stat_rd  = ar_take & (ar_idx == IDX_IRQ_STAT);

   // ===========================================================================
   // Alarm matching and flags
   wire logic [2:0] match_now;
   wire logic [2:0] alarm_ev;
   wire logic [2:0] flag_clr   = wr_clk ? ~wdata_r[CC_FLAG_LSB +: 3] : 3'h0;
   wire logic [2:0] flag_nxt   = events_en_r ? ((flag_r & ~flag_clr) | alarm_ev)
                                             : 3'h0;
   wire logic       clr_en     = clk_cfg_r[CC_CLR_BIT];

   for (genvar n = 0; n < 3; n++)
   begin : g_match
      assign match_now[n] = events_en_r & clk_cfg_r[n] & (timer_value_i == alarm_r[n]);
   end
   assign alarm_ev = match_now & ~match_d_r;

   // ===========================================================================
   // Load capacitance
   wire logic cap_equal    = (applied_r == target_r);
   wire logic cap_settled  = ~auto_step_r | cap_equal;
   wire logic [3:0] applied_nxt =
      ~auto_step_r             ? target_r :
      (applied_r < target_r)   ? applied_r + 4'h1 :
      (applied_r > target_r)   ? applied_r - 4'h1 : applied_r;

   // ===========================================================================
   // Interrupt status
   wire logic [3:0] ev_vec   = {cap_settled & ~settled_d_r, alarm_ev};
   wire logic [3:0] stat_nxt = (stat_r & ~{4{stat_rd}}) | ev_vec;

   // ===========================================================================
   // Read data selection
   wire logic [7:0] ctrl_rd = {ctrl_r.gain_ctrl_en, ctrl_r.osc_source_mode,
                               ctrl_r.bias_double_en, amp_ok_r & ctrl_r.bias_double_en,
                               ctrl_r.internal_lfo_select, 3'h0};
   wire logic [7:0] cfg_rd  = {auto_step_r, cap_settled, 2'h0, target_r};
   wire logic [7:0] clk_rd  = {1'h0, flag_r, clk_cfg_r};
   wire logic [31:0] rd_word =
      (ar_idx == IDX_OSC_CTRL) ? {24'h0, ctrl_rd} :
      (ar_idx == IDX_OSC_CFG)  ? {24'h0, cfg_rd} :
      (ar_idx == IDX_CLK_CFG)  ? {24'h0, clk_rd} :
      (ar_idx == IDX_ALM_CTRL) ? {31'h0, events_en_r} :
      (ar_idx == IDX_ALARM0)   ? alarm_r[0] :
      (ar_idx == IDX_ALARM1)   ? alarm_r[1] :
      (ar_idx == IDX_ALARM2)   ? alarm_r[2] :
      (ar_idx == IDX_IRQ_STAT) ? {28'h0, stat_r} :
      (ar_idx == IDX_IRQ_MASK) ? {28'h0, mask_r} : 32'h0;

   // ===========================================================================
   // AXI write channel
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
         wr_idx_r  <= 6'h00;
         wdata_r   <= 32'h0;
         wstrb_r   <= 4'h0;
      end
      else if (ce_i)
      begin
         if (aw_take)
         begin
            awready_r <= 1'b0;
            wr_idx_r  <= idx_of(s_axi_awaddr_i);
         end
         if (w_take)
         begin
            wready_r <= 1'b0;
            wdata_r  <= s_axi_wdata_i;
            wstrb_r  <= s_axi_wstrb_i;
         end
         if (wr_fire)
         begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (b_take)
         begin
            bvalid_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
         end
      end
   end

   // ===========================================================================
   // AXI read channel
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rd_r      <= '0;
      end
      else if (ce_i)
      begin
         if (ar_take)
         begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rd_r.data <= rd_word;
            rd_r.resp <= mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (r_take)
         begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
         end
      end
   end

   // ===========================================================================
   // Oscillator control and configuration
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         ctrl_r      <= OSC_CTRL_RST;
         amp_ok_r    <= 1'b0;
         auto_step_r <= 1'b0;
         target_r    <= LOAD_CAP_RST;
         applied_r   <= LOAD_CAP_RST;
         settled_d_r <= 1'b1;
         clk_src_r   <= SRC_SELF;
      end
      else if (ce_i)
      begin
         if (wr_ctrl)
         begin
            ctrl_r <= {wdata_r[OC_GAIN_BIT], wdata_r[OC_MODE_BIT],
                       wdata_r[OC_BIAS_BIT], wdata_r[OC_LFO_BIT]};
         end
         if (wr_cfg)
         begin
            auto_step_r <= wdata_r[CF_AUTO_BIT];
            target_r    <= wdata_r[3:0];
         end
         amp_ok_r    <= amplitude_detect_i & ctrl_r.bias_double_en;
         applied_r   <= applied_nxt;
         settled_d_r <= cap_settled;
         clk_src_r   <= ctrl_r.internal_lfo_select ? SRC_LFO :
                        ctrl_r.osc_source_mode     ? SRC_XTAL : SRC_SELF;
      end
   end

   // ===========================================================================
   // Alarm configuration, flags and timer clear
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         clk_cfg_r   <= CLK_CFG_RST;
         flag_r      <= 3'h0;
         events_en_r <= 1'b0;
         match_d_r   <= 3'h0;
         clr_r       <= 1'b0;
         for (int n = 0; n < 3; n++)
         begin
            alarm_r[n] <= 32'h0;
         end
      end
      else if (ce_i)
      begin
         if (wr_clk)
         begin
            clk_cfg_r <= wdata_r[3:0];
         end
         if (wr_alm)
         begin
            events_en_r <= wdata_r[AC_EVENTS_BIT];
         end
         for (int n = 0; n < 3; n++)
         begin
            if (wr_fire && (wr_idx_r == IDX_ALARM0 + 6'(n)))
            begin
               alarm_r[n] <= merge(alarm_r[n], wdata_r, wstrb_r);
            end
         end
         flag_r    <= flag_nxt;
         match_d_r <= match_now;
         clr_r     <= alarm_ev[0] & clr_en;
      end
   end

   // ===========================================================================
   // Interrupt status and mask
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         stat_r <= 4'h0;
         mask_r <= IRQ_MASK_RST;
         irq_r  <= 1'b0;
      end
      else if (ce_i)
      begin
         stat_r <= stat_nxt;
         if (wr_mask)
         begin
            mask_r <= wdata_r[3:0];
         end
         irq_r <= |(stat_r & mask_r);
      end
   end

   // ===========================================================================
   // Outputs
   assign s_axi_awready_o    = awready_r;
   assign s_axi_wready_o     = wready_r;
   assign s_axi_bvalid_o     = bvalid_r;
   assign s_axi_bresp_o      = bresp_r;
   assign s_axi_arready_o    = arready_r;
   assign s_axi_rvalid_o     = rvalid_r;
   assign s_axi_rdata_o      = rd_r.data;
   assign s_axi_rresp_o      = rd_r.resp;
   assign gain_ctrl_en_o     = ctrl_r.gain_ctrl_en;
   assign bias_double_en_o   = ctrl_r.bias_double_en;
   assign lfo_enable_o       = ctrl_r.internal_lfo_select;
   assign clk_src_o          = clk_src_r;
   assign load_cap_applied_o = applied_r;
   assign timer_clear_o      = clr_r;
   assign irq_o              = irq_r;

   // ===========================================================================
   // Assertions
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   sequence s_alarm0_auto;
      ce_i && alarm_ev[0] && clr_en;
   endsequence

   sequence s_clear_pulse;
      timer_clear_o;
   endsequence

   AST_CTRL_LOW_ZERO: assert property (
      (ce_i && ar_take && ar_idx == IDX_OSC_CTRL) |=> (s_axi_rdata_o[2:0] == 3'h0))
      else $error("Oscillator control low bits not zero");

   AST_GAIN_FOLLOWS: assert property (
      (ce_i && wr_ctrl) |=> (gain_ctrl_en_o == $past(wdata_r[OC_GAIN_BIT])))
      else $error("Gain control enable not taken from write");

   AST_SRC_MODE: assert property (
      (ce_i && !ctrl_r.internal_lfo_select)
      |=> (clk_src_o == ($past(ctrl_r.osc_source_mode) ? SRC_XTAL : SRC_SELF)))
      else $error("Clock source does not follow mode bit");

   AST_BIAS_FOLLOWS: assert property (
      (ce_i && wr_ctrl) |=> (bias_double_en_o == $past(wdata_r[OC_BIAS_BIT])))
      else $error("Bias double enable not taken from write");

   AST_AMP_NEEDS_BIAS: assert property (
      (ce_i && !ctrl_r.bias_double_en) |=> !amp_ok_r)
      else $error("Amplitude ok set without doubled bias");

   AST_SRC_LFO: assert property (
      (ce_i && ctrl_r.internal_lfo_select)
      |=> (clk_src_o == SRC_LFO
           && lfo_enable_o == ($past(wr_ctrl) ? $past(wdata_r[OC_LFO_BIT]) : 1'b1)))
      else $error("Internal oscillator select not honoured");

   AST_CAP_STEP_UP: assert property (
      (ce_i && auto_step_r && applied_r < target_r)
      |=> (load_cap_applied_o == $past(applied_r) + 4'h1))
      else $error("Capacitance did not step up by one");

   AST_SETTLED_READ: assert property (
      (ce_i && ar_take && ar_idx == IDX_OSC_CFG)
      |=> (s_axi_rdata_o[CF_SETTLED_BIT] == ($past(cap_equal) || !$past(auto_step_r))))
      else $error("Settled indicator mismatch");

   AST_CFG_UNUSED: assert property (
      (ce_i && ar_take && ar_idx == IDX_OSC_CFG) |=> (s_axi_rdata_o[5:4] == 2'h0))
      else $error("Unused configuration bits not zero");

   AST_CLK_RSVD: assert property (
      (ce_i && ar_take && ar_idx == IDX_CLK_CFG) |=> !s_axi_rdata_o[7])
      else $error("Reserved clock configuration bit not zero");

   AST_FLAG2_SET: assert property (
      (ce_i && alarm_ev[2]) |=> flag_r[2])
      else $error("Match-2 flag not set by alarm");

   AST_MATCH_EQ: assert property (
      alarm_ev[0] |-> (timer_value_i == alarm_r[0]))
      else $error("Alarm 0 event without timer match");

   AST_TIMER_CLEAR: assert property (
      s_alarm0_auto |-> ##1 s_clear_pulse)
      else $error("Timer clear not issued after alarm 0");

   AST_EVENTS_OFF: assert property (
      (ce_i && !events_en_r) |=> (flag_r == 3'h0))
      else $error("Flags kept while alarm events disabled");

   AST_CAP_DIRECT: assert property (
      (ce_i && !auto_step_r) |=> (load_cap_applied_o == $past(target_r)))
      else $error("Capacitance does not follow target directly");

endmodule

`default_nettype wire

// *** testbench/tb_top.sv ***
// Purpose : Self-checking bench for the oscillator control block
// Assumes : Bench acts as AXI4-Lite master; timer value driven here
// Notes   : A cycle ceiling cuts a hang short
`timescale 1ns/1ps
`default_nettype none

module tb_top
   import rtcoc_pkg::*;
();

   // ==========================================================================
   // Stimulus and observed signals
   logic              clk_sys_i    = 1'b0;
   logic              rst_i        = 1'b1;
   logic [7:0]        awaddr       = 8'h00;
   logic [7:0]        araddr       = 8'h00;
   logic [31:0]       wdata        = 32'h0;
   logic [31:0]       tval         = 32'hFFFF_FFFF;
   logic              awvalid      = 1'b0;
   logic              wvalid       = 1'b0;
   logic              bready       = 1'b0;
   logic              arvalid      = 1'b0;
   logic              rready       = 1'b0;
   logic              amp_det      = 1'b1;
   logic              ce           = 1'b1;
   logic              awready;
   logic              wready;
   logic              bvalid;
   logic              arready;
   logic              rvalid;
   logic              gain;
   logic              bias;
   logic              lfo;
   logic              tclr;
   logic              irq;
   logic [1:0]        bresp;
   logic [1:0]        rresp;
   logic [1:0]        src;
   logic [3:0]        cap;
   logic [31:0]       rdata;
   int                bad_count    = 0;
   int                total_checks = 0;
   int                cyc          = 0;

   rtcoc_top dut (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .amplitude_detect_i(amp_det), .gain_ctrl_en_o(gain), .bias_double_en_o(bias),
      .lfo_enable_o(lfo), .clk_src_o(src), .load_cap_applied_o(cap),
      .timer_value_i(tval), .timer_clear_o(tclr), .irq_o(irq)
   );

   // ==========================================================================
   // Shared tasks
   task automatic results;
      if (bad_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk_sys_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge clk_sys_i);
         aw_ok = aw_ok | (awvalid & (awready === 1'b1));
         w_ok = w_ok | (wvalid & (wready === 1'b1));
         awvalid <= ~aw_ok;
         wvalid <= ~w_ok;
      end
      while (bvalid !== 1'b1)
         @(posedge clk_sys_i);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge clk_sys_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge clk_sys_i);
      while (arready !== 1'b1)
         @(posedge clk_sys_i);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1)
         @(posedge clk_sys_i);
      rready <= 1'b0;
      chk({30'h0, rresp}, {30'h0, er});
      chk(rdata, exp);
   endtask

   task automatic pins(input logic [1:0] s, input logic [2:0] glb);
      repeat (3) @(posedge clk_sys_i);
      chk({30'h0, src}, {30'h0, s});
      chk({29'h0, gain, bias, lfo}, {29'h0, glb});
   endtask

   task automatic hit(input logic [31:0] v, input int pulses);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      tval <= v;
      repeat (6)
      begin
         @(posedge clk_sys_i);
         n += int'(tclr === 1'b1);
      end
      chk(32'(n), 32'(pulses));
   endtask

   // ==========================================================================
   // Scenarios
   task automatic t_reset;
      rd(8'h14, 32'h0, RESP_OKAY);
      rd(8'h18, 32'h40, RESP_OKAY);
      rd(8'h1C, 32'h0, RESP_OKAY);
      pins(SRC_SELF, 3'b000);
   endtask

   task automatic t_osc;
      wr(8'h14, 32'hFF, RESP_OKAY);
      rd(8'h14, 32'hF8, RESP_OKAY);
      amp_det <= 1'b0;
      rd(8'h14, 32'hE8, RESP_OKAY);
      amp_det <= 1'b1;
      pins(SRC_LFO, 3'b111);
      wr(8'h14, 32'h40, RESP_OKAY);
      rd(8'h14, 32'h40, RESP_OKAY);
      pins(SRC_XTAL, 3'b000);
      wr(8'h14, 32'h08, RESP_OKAY);
      pins(SRC_LFO, 3'b001);
      wr(8'h14, 32'h00, RESP_OKAY);
      pins(SRC_SELF, 3'b000);
   endtask

   task automatic t_cap;
      logic [3:0] held;
      wr(8'h18, 32'h3A, RESP_OKAY);
      rd(8'h18, 32'h4A, RESP_OKAY);
      chk({28'h0, cap}, 32'hA);
      wr(8'h18, 32'h83, RESP_OKAY);
      rd(8'h18, 32'h83, RESP_OKAY);
      ce <= 1'b0;
      @(posedge clk_sys_i);
      held = cap;
      repeat (4) @(posedge clk_sys_i);
      chk({28'h0, cap}, {28'h0, held});
      ce <= 1'b1;
      repeat (20) @(posedge clk_sys_i);
      rd(8'h18, 32'hC3, RESP_OKAY);
      chk({28'h0, cap}, 32'h3);
   endtask

   task automatic t_alarm;
      wr(8'h24, 32'h100, RESP_OKAY);
      wr(8'h28, 32'h200, RESP_OKAY);
      wr(8'h2C, 32'h300, RESP_OKAY);
      wr(8'h1C, 32'h0F, RESP_OKAY);
      wr(8'h34, 32'h1, RESP_OKAY);
      wr(8'h20, 32'h1, RESP_OKAY);
      rd(8'h30, 32'h8, RESP_OKAY);
      hit(32'h100, 1);
      rd(8'h1C, 32'h1F, RESP_OKAY);
      chk({31'h0, irq}, 32'h1);
      hit(32'h101, 0);
      hit(32'h200, 0);
      rd(8'h1C, 32'h3F, RESP_OKAY);
      hit(32'h300, 0);
      hit(32'h0, 0);
      rd(8'h1C, 32'h7F, RESP_OKAY);
      wr(8'h1C, 32'h0F, RESP_OKAY);
      rd(8'h1C, 32'h0F, RESP_OKAY);
      rd(8'h30, 32'h7, RESP_OKAY);
      repeat (2) @(posedge clk_sys_i);
      chk({31'h0, irq}, 32'h0);
      hit(32'h100, 1);
      wr(8'h20, 32'h0, RESP_OKAY);
      rd(8'h1C, 32'h0F, RESP_OKAY);
      wr(8'h00, 32'hFF, RESP_SLVERR);
      rd(8'h3C, 32'h0, RESP_SLVERR);
   endtask

   // ==========================================================================
   // Clock, ceiling and main sequence
   initial
   begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         bad_count++;
         results();
      end
   end

   initial
   begin
      repeat (10) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      t_reset();
      t_osc();
      t_cap();
      t_alarm();
      results();
   end

endmodule

`default_nettype wire
